// ### verilog/dtzq_top.sv
// module: training fifo, thermal status and background calibration control
`timescale 1ns/10ps
`default_nettype none
module dtzq_top #(
  parameter int unsigned TSI_CYC = dtzq_pkg::TTSI_CYC
) (
  // clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // decoded command bus
  input  wire logic        i_cmd_mpc,
  input  wire logic [6:0]  i_cmd_op,
  input  wire logic        i_cmd_cas2,
  input  wire logic [5:0]  i_cas2_opnd,
  input  wire logic        i_cmd_wr,
  input  wire logic        i_cmd_rd,
  input  wire logic        i_cmd_mrr,
  input  wire logic        i_cke,
  input  wire logic        i_pd,
  input  wire logic        i_sref,
  // fifo write data
  input  wire logic        i_wf_valid,
  input  wire logic [15:0] i_wf_data,
  input  wire logic [1:0]  i_wf_dmi,
  // sensor and calibration engine
  input  wire logic [2:0]  i_temp_raw,
  input  wire logic [5:0]  i_zq_result,
  // training read data
  output logic             o_rd_valid,
  output logic [15:0]      o_rd_data,
  output logic             o_rd_undef,
  output logic             o_dmi_oe,
  output logic [1:0]       o_dmi_out,
  output logic             o_cas2_err,
  // thermal and impedance
  output logic [2:0]       o_temp_compensated_refresh,
  output logic [5:0]       o_zq_code,
  output logic             o_zq_busy
);
  localparam int unsigned EW = dtzq_pkg::DQ_W + 4;

  // ****************************************
  // apb decode
  // ****************************************
  logic        acc, wr_en, mapped;
  logic [31:0] rdata;
  logic [2:0]  en_q;
  logic [4:0]  rl_q;
  logic [1:0]  ofs_q;
  logic [2:0]  ts_q;
  logic [5:0]  zq_code_q, done_code_q;
  logic        zq_def_q, have_done_q;
  logic [2:0]  wptr_q, rptr_q;
  logic [31:0] prdata_q;
  dtzq_pkg::dtzq_zq_t zq_st_q;

  assign acc    = i_psel & i_penable;
  assign wr_en  = acc & i_pwrite & i_ce;
  assign mapped = (i_paddr == dtzq_pkg::REG_CFG) || (i_paddr == dtzq_pkg::REG_STAT) ||
                  (i_paddr == dtzq_pkg::REG_MR4) || (i_paddr == dtzq_pkg::REG_MR10);
  assign o_pready  = 1'b1;
  assign o_pslverr = acc & ~mapped;
  assign o_prdata  = prdata_q;

  // read mux
  always_comb begin
    rdata = '0;
    if (i_paddr == dtzq_pkg::REG_CFG) begin
      rdata[dtzq_pkg::CFG_WDBI +: 3]   = en_q;
      rdata[dtzq_pkg::CFG_RL_LSB +: 5] = rl_q;
    end else if (i_paddr == dtzq_pkg::REG_STAT) begin
      rdata[dtzq_pkg::ST_ZQBUSY]        = (zq_st_q == dtzq_pkg::ZQ_RUN);
      rdata[dtzq_pkg::ST_ZQDEF]         = zq_def_q;
      rdata[dtzq_pkg::ST_CODE_LSB +: 6] = zq_code_q;
      rdata[dtzq_pkg::ST_WP_LSB +: 3]   = wptr_q;
      rdata[dtzq_pkg::ST_RP_LSB +: 3]   = rptr_q;
    end else if (i_paddr == dtzq_pkg::REG_MR4) begin
      rdata[dtzq_pkg::MR4_TS_LSB +: 3]  = ts_q;
      rdata[dtzq_pkg::MR4_OFS_LSB +: 2] = ofs_q;
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prdata_q <= '0;
    end else if (i_ce && i_psel && !i_penable) begin
      prdata_q <= rdata;
    end
  end

  // configuration register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      en_q <= '0;
      rl_q <= dtzq_pkg::RL_RST;
    end else if (wr_en && i_paddr == dtzq_pkg::REG_CFG) begin
      en_q <= i_pwdata[dtzq_pkg::CFG_WDBI +: 3];
      rl_q <= i_pwdata[dtzq_pkg::CFG_RL_LSB +: 5];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ofs_q <= '0;
    end else if (wr_en && i_paddr == dtzq_pkg::REG_MR4) begin
      ofs_q <= i_pwdata[dtzq_pkg::MR4_OFS_LSB +: 2];
    end
  end

  // ****************************************
  // command decode
  // ****************************************
  dtzq_pkg::dtzq_cmd_t cmd_q;
  logic rd_exec, dq_exec, zq_start, zq_latch, disturb;

  // training reads wait for the CAS-2; fifo writes follow i_wf_valid alone
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cmd_q <= dtzq_pkg::CMD_IDLE;
    end else if (i_ce) begin
      cmd_q <= dtzq_pkg::CMD_IDLE;
      if (i_cmd_mpc) begin
        case (i_cmd_op)
          dtzq_pkg::OP_RD_FIFO:  cmd_q <= dtzq_pkg::CMD_RDF;
          dtzq_pkg::OP_WR_FIFO:  cmd_q <= dtzq_pkg::CMD_WRF;
          dtzq_pkg::OP_RD_DQCAL: cmd_q <= dtzq_pkg::CMD_DQCAL;
          default:               cmd_q <= dtzq_pkg::CMD_IDLE;
        endcase
      end
    end
  end

  // accepted in any bank or refresh state while clock enable is high
  assign rd_exec  = i_ce & i_cke & i_cmd_cas2 & (cmd_q == dtzq_pkg::CMD_RDF);
  assign dq_exec  = i_ce & i_cmd_cas2 & (cmd_q == dtzq_pkg::CMD_DQCAL);
  assign zq_start = i_ce & i_cmd_mpc & (i_cmd_op == dtzq_pkg::OP_ZQ_START);
  assign zq_latch = i_ce & i_cmd_mpc & (i_cmd_op == dtzq_pkg::OP_ZQ_LATCH);
  // foreign commands and low cke zero the fifo pointers
  assign disturb  = i_cmd_wr | i_cmd_rd | i_cmd_mrr | dq_exec | ~i_cke;

  // flag non-zero operands on a training CAS-2
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cas2_err <= 1'b0;
    end else if (i_ce) begin
      o_cas2_err <= i_cmd_cas2 & (cmd_q != dtzq_pkg::CMD_IDLE) & (i_cas2_opnd != '0);
    end
  end

  // ****************************************
  // training fifo
  // ****************************************
  logic [EW-3:0]           mem [dtzq_pkg::FIFO_D];
  logic [dtzq_pkg::FIFO_D-1:0] wrote_q;

  // data storage
  always_ff @(posedge i_clk) begin
    if (i_ce && i_wf_valid) begin
      mem[wptr_q] <= {i_wf_dmi, i_wf_data};
    end
  end

  // pointers advance and wrap after five entries
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      wrote_q <= '0;
    end else if (i_ce) begin
      if (disturb) begin
        wptr_q <= '0;
        rptr_q <= '0;
      end else begin
        if (i_wf_valid) begin
          wptr_q          <= (wptr_q == dtzq_pkg::PTR_MAX) ? '0 : wptr_q + 3'h1;
          wrote_q[wptr_q] <= 1'b1;
        end
        if (rd_exec) begin
          rptr_q <= (rptr_q == dtzq_pkg::PTR_MAX) ? '0 : rptr_q + 3'h1;
        end
      end
    end
  end

  // ****************************************
  // read latency pipeline
  // ****************************************
  logic [EW-1:0] pipe_q [dtzq_pkg::PIPE_D];
  logic [4:0]    ins;
  logic [EW-1:0] entry;

  // insertion slot set by the read latency
  assign ins   = (rl_q == '0) ? '0 : rl_q - 5'h1;
  // unwritten entries read as zero with a flag
  assign entry = wrote_q[rptr_q] ? {2'b10, mem[rptr_q]} : {2'b11, {(EW-2){1'b0}}};

  // one slot per command, so back-to-back reads never collide
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < dtzq_pkg::PIPE_D; i++) pipe_q[i] <= '0;
    end else if (i_ce) begin
      for (int i = 0; i < dtzq_pkg::PIPE_D - 1; i++) pipe_q[i] <= pipe_q[i+1];
      pipe_q[dtzq_pkg::PIPE_D-1] <= '0;
      if (rd_exec) begin
        pipe_q[ins] <= entry;
      end
    end
  end

  // pipe word: valid, undefined flag, dmi, data
  logic [EW-1:0] head;
  logic          head_undef;
  assign head       = pipe_q[0];
  assign head_undef = head[EW-2];
  assign o_rd_valid = head[EW-1];
  assign o_rd_data  = head[dtzq_pkg::DQ_W-1:0];
  assign o_rd_undef = head_undef;
  // mask pins driven when any inversion or masking mode is on
  assign o_dmi_oe   = head[EW-1] & (en_q != '0);
  assign o_dmi_out  = head_undef ? 2'h0 : head[dtzq_pkg::DQ_W +: 2];

  // ****************************************
  // temperature status
  // ****************************************
  logic       tsi_busy, tsi_done, ofs_chg, lp_q, lp_exit;
  logic [3:0] tsum;
  logic [2:0] ts_d;
  logic [1:0] ofs_seen_q;

  dtzq_timer #(.W(dtzq_pkg::TMR_W)) u_tsi (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_load  (~tsi_busy),
    .i_count (dtzq_pkg::TMR_W'(TSI_CYC - 1)),
    .o_busy  (tsi_busy),
    .o_done  (tsi_done)
  );

  assign tsum    = {1'b0, i_temp_raw} + {2'b00, ofs_q};
  assign ts_d    = tsum[3] ? 3'h7 : tsum[2:0];
  assign ofs_chg = (ofs_q != ofs_seen_q);
  assign lp_exit = lp_q & ~(i_sref | i_pd);

  // low-power tracking
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lp_q       <= 1'b0;
      ofs_seen_q <= '0;
    end else if (i_ce) begin
      lp_q       <= i_sref | i_pd;
      ofs_seen_q <= ofs_q;
    end
  end

  // periodic update and on leaving low power
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ts_q <= '0;
    end else if (i_ce && (tsi_done || ofs_chg || lp_exit)) begin
      ts_q <= ts_d;
    end
  end
  assign o_temp_compensated_refresh = ts_q;

  // ****************************************
  // background impedance calibration
  // ****************************************
  logic zq_go, zq_busy, zq_done, zq_reset;

  assign zq_go    = zq_start & ~i_pd & (zq_st_q == dtzq_pkg::ZQ_IDLE);
  // one to bit 0 of mode ten resets this channel
  assign zq_reset = wr_en & (i_paddr == dtzq_pkg::REG_MR10) & i_pwdata[dtzq_pkg::MR10_ZQRST];

  dtzq_timer #(.W(dtzq_pkg::TMR_W)) u_zq (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_load  (zq_go),
    .i_count (dtzq_pkg::TMR_W'(dtzq_pkg::TZQCAL_CYC)),
    .o_busy  (zq_busy),
    .o_done  (zq_done)
  );

  // calibration state and result capture
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      zq_st_q     <= dtzq_pkg::ZQ_IDLE;
      done_code_q <= dtzq_pkg::ZQ_DEF;
      have_done_q <= 1'b0;
    end else if (i_ce) begin
      case (zq_st_q)
        dtzq_pkg::ZQ_IDLE: if (zq_go) zq_st_q <= dtzq_pkg::ZQ_RUN;
        dtzq_pkg::ZQ_RUN: begin
          if (zq_done) begin
            zq_st_q     <= dtzq_pkg::ZQ_IDLE;
            done_code_q <= i_zq_result;
            have_done_q <= 1'b1;
          end
        end
        default: zq_st_q <= dtzq_pkg::ZQ_IDLE;
      endcase
    end
  end

  // latch takes the newest completed result
  // code belongs to this channel only
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      zq_code_q <= dtzq_pkg::ZQ_DEF;
      zq_def_q  <= 1'b1;
    end else if (i_ce) begin
      if (zq_reset) begin
        zq_code_q <= dtzq_pkg::ZQ_DEF;
        zq_def_q  <= 1'b1;
      end else if (zq_latch && have_done_q) begin
        zq_code_q <= done_code_q;
        zq_def_q  <= 1'b0;
      end
    end
  end
  assign o_zq_code = zq_code_q;
  assign o_zq_busy = zq_busy;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst || !i_ce);
  localparam int RL_CHK = int'(dtzq_pkg::RL_RST);

  sequence rd_issue_s;
    rd_exec && rl_q == dtzq_pkg::RL_RST;
  endsequence
  sequence data_out_s;
    o_rd_valid;
  endsequence

  rd_latency_a: assert property (rd_issue_s |-> ##RL_CHK data_out_s)
    else $error("training read data not at read latency");
  ptr_wrap_a: assert property (rd_exec && !disturb && rptr_q == 3'h4 |=> rptr_q == 3'h0)
    else $error("read pointer did not wrap after five");
  rd_undef_a: assert property (rd_exec && !wrote_q[rptr_q] && rl_q == dtzq_pkg::RL_RST |-> ##RL_CHK o_rd_undef)
    else $error("unwritten entry not flagged");
  dmi_drive_a: assert property (o_rd_valid && en_q != 3'h0 |-> o_dmi_oe)
    else $error("mask pins not driven");
  zq_ignore_a: assert property (zq_st_q == dtzq_pkg::ZQ_RUN && zq_start && !zq_done |=>
                                zq_st_q == dtzq_pkg::ZQ_RUN)
    else $error("running calibration disturbed");
  zq_pd_a: assert property (zq_start && i_pd && zq_st_q == dtzq_pkg::ZQ_IDLE |=> zq_st_q == dtzq_pkg::ZQ_IDLE)
    else $error("start accepted in power-down");
  zq_latch_a: assert property (zq_latch && have_done_q && !zq_reset |=> o_zq_code == $past(done_code_q))
    else $error("latch loaded wrong result");
  zq_reset_a: assert property (zq_reset |=> o_zq_code == dtzq_pkg::ZQ_DEF && zq_def_q)
    else $error("calibration reset not applied");
  ts_offset_a: assert property ($changed(ofs_q) |-> ##[1:2] ts_q == $past(ts_d))
    else $error("thermal offset not reflected");
endmodule // dtzq_top
`default_nettype wire

// ### verilog/dtzq_pkg.sv
// package: constants for the training, thermal and calibration block
package dtzq_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TTSI_MS       = 32;
  // longest interval rounds down
  localparam int unsigned TTSI_CYC      = TTSI_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned TOFS_US       = 200;
  localparam int unsigned TOFS_CYC      = TOFS_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TZQCAL_NS     = 1000;
  // least time rounds up
  localparam int unsigned TZQCAL_CYC    = (TZQCAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W         = 20;

  // ****************************************
  // multi-purpose command operands
  // ****************************************
  localparam logic [6:0] OP_RD_FIFO  = 7'h41;
  localparam logic [6:0] OP_RD_DQCAL = 7'h43;
  localparam logic [6:0] OP_WR_FIFO  = 7'h47;
  localparam logic [6:0] OP_ZQ_START = 7'h4F;
  localparam logic [6:0] OP_ZQ_LATCH = 7'h51;

  // ****************************************
  // training fifo and read pipeline
  // ****************************************
  localparam int unsigned     FIFO_D  = 5;
  localparam int unsigned     PTR_W   = 3;
  localparam logic [2:0]      PTR_MAX = 3'h4;
  localparam int unsigned     DQ_W    = 16;
  localparam int unsigned     RL_W    = 5;
  localparam int unsigned     PIPE_D  = 32;
  localparam logic [4:0]      RL_RST  = 5'h06;
  localparam int unsigned     ZQ_W    = 6;
  localparam logic [5:0]      ZQ_DEF  = 6'h20;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [7:0] REG_CFG  = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_MR4  = 8'h10;
  localparam logic [7:0] REG_MR10 = 8'h28;
  localparam int unsigned CFG_WDBI   = 0;
  localparam int unsigned CFG_RDBI   = 1;
  localparam int unsigned CFG_DM     = 2;
  localparam int unsigned CFG_RL_LSB = 8;
  localparam int unsigned MR4_TS_LSB = 0;
  localparam int unsigned MR4_OFS_LSB = 5;
  localparam int unsigned MR10_ZQRST = 0;
  localparam int unsigned ST_ZQBUSY  = 0;
  localparam int unsigned ST_ZQDEF   = 1;
  localparam int unsigned ST_CODE_LSB = 8;
  localparam int unsigned ST_WP_LSB  = 16;
  localparam int unsigned ST_RP_LSB  = 20;

  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [1:0] {
    CMD_IDLE  = 2'b00,
    CMD_RDF   = 2'b01,
    CMD_WRF   = 2'b10,
    CMD_DQCAL = 2'b11
  } dtzq_cmd_t;

  typedef enum logic {
    ZQ_IDLE = 1'b0,
    ZQ_RUN  = 1'b1
  } dtzq_zq_t;

endpackage

// ### verilog/dtzq_timer.sv
// module: loadable down counter with a one-cycle done pulse
`timescale 1ns/10ps
`default_nettype none
module dtzq_timer #(
  parameter int unsigned W = 20
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // control
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  // status
  output logic              o_busy,
  output logic              o_done
);
  logic [W-1:0] cnt_q;
  logic         done_q;

  // ****************************************
  // counter
  // ****************************************
  // count down, pulse done on reaching zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else if (i_ce) begin
      done_q <= 1'b0;
      if (i_load) begin
        cnt_q <= i_count;
      end else if (cnt_q != '0) begin
        cnt_q  <= cnt_q - 1'b1;
        done_q <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
      end
    end
  end

  assign o_busy = (cnt_q != '0);
  assign o_done = done_q;
endmodule // dtzq_timer
`default_nettype wire

// ### tb/dtzq_ctrl_model.sv
// controller-side model driving the training command bus
`timescale 1ns/10ps
`default_nettype none
module dtzq_ctrl_model (
  // clock
  input  wire logic       i_clk,
  // command bus
  output var logic        o_mpc,
  output var logic [6:0]  o_op,
  output var logic        o_cas2,
  output var logic [5:0]  o_opnd,
  output var logic        o_wr,
  output var logic        o_rd,
  output var logic        o_mrr,
  // fifo write data
  output var logic        o_wf_valid,
  output var logic [15:0] o_wf_data,
  output var logic [1:0]  o_wf_dmi
);
  // ****
  // command tasks
  // ****
  initial begin
    {o_mpc, o_cas2, o_wr, o_rd, o_mrr, o_wf_valid, o_op, o_opnd, o_wf_data, o_wf_dmi} = '0;
  end

  // deselect cycles; released operands keep toggling
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge i_clk);
      {o_mpc, o_cas2, o_wr, o_rd, o_mrr, o_wf_valid} <= '0;
      o_op <= ~o_op;
      o_opnd <= ~o_opnd;
      o_wf_data <= ~o_wf_data;
    end
  endtask

  // mpc with cas-2 right behind when asked
  task automatic mpc(input logic [6:0] op, input logic cas, input logic [5:0] opnd);
    @(posedge i_clk);
    {o_cas2, o_wf_valid, o_wr, o_rd, o_mrr} <= '0;
    o_mpc <= 1'b1;
    o_op <= op;
    @(posedge i_clk);
    o_mpc <= 1'b0;
    o_op <= ~op;
    o_cas2 <= cas;
    o_opnd <= opnd;
  endtask

  // ordinary command pulse: write, read, mode read
  task automatic ord(input logic [2:0] k);
    @(posedge i_clk);
    {o_mpc, o_cas2, o_wf_valid} <= '0;
    {o_wr, o_rd, o_mrr} <= k;
  endtask

  // one beat into the fifo
  task automatic wf(input logic [15:0] d, input logic [1:0] m);
    @(posedge i_clk);
    {o_mpc, o_cas2, o_wr, o_rd, o_mrr} <= '0;
    o_wf_valid <= 1'b1;
    o_wf_data <= d;
    o_wf_dmi <= m;
  endtask
endmodule // dtzq_ctrl_model
`default_nettype wire

// ### tb/test_dtzq_top.sv
// self-checking bench for the training, thermal and calibration block
`timescale 1ns/10ps
`default_nettype none
module test_dtzq_top;
  localparam int TSI = 50;
  logic        clk, rst, ce, psel, penable, pwrite, cke, pd, sref, pready, e;
  logic        mpc, cas2, wr, rd, mrr, wfv, rdv, undef, dmi_oe, cerr, zq_busy, pslverr;
  logic        rdf_q = 1'b0;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [6:0]  op;
  logic [5:0]  opnd, zq_res, zq_code;
  logic [15:0] wfd, rdd;
  logic [1:0]  wfm, dmi;
  logic [2:0]  traw, tcr;
  logic [31:0] vq[$];
  int          cq[$], tq[$];
  int          n_errors = 0, checks = 0, cyc = 0, busy_n = 0, cerr_n = 0, n;

  dtzq_top #(.TSI_CYC(TSI)) dut (
    .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_cmd_mpc(mpc), .i_cmd_op(op), .i_cmd_cas2(cas2), .i_cas2_opnd(opnd), .i_cmd_wr(wr),
    .i_cmd_rd(rd), .i_cmd_mrr(mrr), .i_cke(cke), .i_pd(pd), .i_sref(sref), .i_wf_valid(wfv),
    .i_wf_data(wfd), .i_wf_dmi(wfm), .i_temp_raw(traw), .i_zq_result(zq_res), .o_rd_valid(rdv),
    .o_rd_data(rdd), .o_rd_undef(undef), .o_dmi_oe(dmi_oe), .o_dmi_out(dmi), .o_cas2_err(cerr),
    .o_temp_compensated_refresh(tcr), .o_zq_code(zq_code), .o_zq_busy(zq_busy));

  dtzq_ctrl_model ctrl (
    .i_clk(clk), .o_mpc(mpc), .o_op(op), .o_cas2(cas2), .o_opnd(opnd), .o_wr(wr), .o_rd(rd),
    .o_mrr(mrr), .o_wf_valid(wfv), .o_wf_data(wfd), .o_wf_dmi(wfm));

  // ****
  // clock, monitor and tasks
  // ****
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // records cas-2 and read-data cycles, counts busy and fault cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rdf_q <= mpc && op == dtzq_pkg::OP_RD_FIFO && cke;
    if (cas2 && rdf_q) cq.push_back(cyc);
    if (rdv === 1'b1) begin
      tq.push_back(cyc);
      vq.push_back({12'h0, dmi, undef, dmi_oe, rdd});
    end
    if (zq_busy === 1'b1) busy_n <= busy_n + 1;
    if (cerr === 1'b1) cerr_n <= cerr_n + 1;
    if (cyc > 5000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wrap_up;
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    {rst, ce, psel, penable, pwrite, cke, pd, sref} = 8'hC0;
    paddr = '0;
    pwdata = '0;
    traw = 3'h6;
    zq_res = 6'h11;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cke <= 1'b1;
    apb(0, dtzq_pkg::REG_CFG, 32'h0);
    chk(r, 32'h0000_0600);
    chk({26'h0, zq_code}, {26'h0, dtzq_pkg::ZQ_DEF});
    apb(0, 8'h3C, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    // fifo training in self-refresh, latency 6, masking on
    apb(1, dtzq_pkg::REG_CFG, 32'h0000_0604);
    sref <= 1'b1;
    ctrl.ord(3'h4);
    ctrl.quiet(12);
    ctrl.mpc(dtzq_pkg::OP_WR_FIFO, 1'b1, 6'h0);
    for (int i = 0; i < 3; i++) ctrl.wf(16'(16'h1111 * (i + 1)), 2'(i));
    ctrl.quiet(8);
    for (int i = 0; i < 6; i++) ctrl.mpc(dtzq_pkg::OP_RD_FIFO, 1'b1, 6'h0);
    ctrl.quiet(8);
    chk(32'(vq.size()), 32'h6);
    for (int i = 0; i < 6; i++) begin
      chk(32'(tq[i] - cq[i]), 32'h6);
      chk(vq[i], (i % 5 < 3) ? {12'h0, 2'(i % 5), 2'b01, 16'(16'h1111 * (i % 5 + 1))}
                             : {14'h0, 2'b11, 16'h0});
    end
    apb(0, dtzq_pkg::REG_STAT, 32'h0);
    chk(r & 32'h0077_0000, 32'h0013_0000);
    // mode read, then plain read, each zero both pointers
    for (int k = 1; k < 3; k++) begin
      ctrl.wf(16'h5A5A, 2'h1);
      ctrl.ord(3'(k));
      ctrl.quiet(1);
      apb(0, dtzq_pkg::REG_STAT, 32'h0);
      chk(r & 32'h0077_0000, 32'h0);
    end
    ctrl.mpc(dtzq_pkg::OP_RD_FIFO, 1'b1, 6'h15);
    ctrl.quiet(8);
    chk(32'(cerr_n), 32'h1);
    cke <= 1'b0;
    n = vq.size();
    ctrl.mpc(dtzq_pkg::OP_RD_FIFO, 1'b1, 6'h0);
    ctrl.quiet(8);
    chk(32'(vq.size() - n), 32'h0);
    cke <= 1'b1;
    sref <= 1'b0;
    // thermal status and offset
    ctrl.quiet(TSI + 5);
    apb(0, dtzq_pkg::REG_MR4, 32'h0);
    chk(r & 32'h7, 32'h6);
    traw <= 3'h2;
    ctrl.quiet(TSI + 5);
    // offset write while frozen is lost
    ce <= 1'b0;
    apb(1, dtzq_pkg::REG_MR4, 32'h60);
    ce <= 1'b1;
    apb(0, dtzq_pkg::REG_MR4, 32'h0);
    chk(r & 32'h67, 32'h2);
    apb(1, dtzq_pkg::REG_MR4, 32'h60);
    ctrl.quiet(2);
    apb(0, dtzq_pkg::REG_MR4, 32'h0);
    chk(r & 32'h67, 32'h65);
    chk({29'h0, tcr}, 32'h5);
    // background calibration
    ctrl.mpc(dtzq_pkg::OP_ZQ_START, 1'b0, 6'h0);
    ctrl.quiet(2);
    ctrl.mpc(dtzq_pkg::OP_ZQ_START, 1'b0, 6'h0);
    ctrl.mpc(dtzq_pkg::OP_ZQ_LATCH, 1'b0, 6'h0);
    ctrl.quiet(1);
    chk({26'h0, zq_code}, {26'h0, dtzq_pkg::ZQ_DEF});
    zq_res <= 6'h2A;
    ctrl.quiet(12);
    chk(32'(busy_n), 32'(dtzq_pkg::TZQCAL_CYC));
    ctrl.mpc(dtzq_pkg::OP_ZQ_LATCH, 1'b0, 6'h0);
    ctrl.quiet(2);
    chk({26'h0, zq_code}, 32'h2A);
    pd <= 1'b1;
    ctrl.mpc(dtzq_pkg::OP_ZQ_START, 1'b0, 6'h0);
    ctrl.quiet(3);
    chk({31'h0, zq_busy}, 32'h0);
    pd <= 1'b0;
    apb(1, dtzq_pkg::REG_MR10, 32'h1);
    ctrl.quiet(2);
    chk({26'h0, zq_code}, {26'h0, dtzq_pkg::ZQ_DEF});
    wrap_up();
  end
endmodule // test_dtzq_top
`default_nettype wire
